// File: bench/itw_watch_model.sv
/*
 * watch timer side: counts main clock cycles between rising edges of the watch clock
 * assumes the watch clock is a registered level on mclk
 */
`timescale 1ns/1ps

module itw_watch_model (
	input  wire logic mclk,
	input  wire logic watch_count_clk,
	output int        period,
	output int        rises
);
	// ==========================================================
	// edge sampling
	int   cnt;
	logic last;

	initial begin
		cnt = 0;
		last = 1'b0;
		period = 0;
		rises = 0;
	end

	always @(posedge mclk) begin
		last <= watch_count_clk;
		if (watch_count_clk === 1'b1 && last === 1'b0) begin
			period <= cnt;
			rises <= rises + 1;
			cnt <= 1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// File: bench/tb_interval_timer_with_watch_clock.sv
/*
 * self-checking bench: apb registers, intervals, watch clock, gating, interrupt
 * assumes itw_pkg, itw_timer and itw_watch_model are compiled before it
 */
`timescale 1ns/1ps

module tb_interval_timer_with_watch_clock
	import itw_pkg::*;
;
	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, er;
	logic        interval_irq, watch_count_clk, irq;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0]  pstrb;
	int          n_fail, n_checks, period, rises;

	itw_timer DUT (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.interval_irq(interval_irq), .watch_count_clk(watch_count_clk), .irq(irq));
	itw_watch_model u_watch (.mclk(mclk), .watch_count_clk(watch_count_clk),
		.period(period), .rises(rises));

	// ==========================================================
	// helpers
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task complete_run;
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one transfer, then an idle edge so the next setup never collides
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int w;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge mclk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		chk("pready", 1, 32'(pready));
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task next_irq(output int c);
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while (interval_irq !== 1'b1 && c < 5000);
		chk("irq wait", 1, 32'(interval_irq));
	endtask

	function logic [31:0] md(input logic run, input logic gate, input logic [1:0] m);
		return {24'h00_0000, run, gate, 4'h0, m};
	endfunction

	function logic [31:0] gap(input int m, input int n);
		return 32'(((n == 0) ? 256 : n) << m);
	endfunction

	// ==========================================================
	// watchdog and main sequence
	initial begin
		#3_000_000;
		n_fail++;
		complete_run();
	end

	initial begin
		int c, n, v;
		n_fail = 0;
		n_checks = 0;
		rstn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		void'($urandom(9));
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		apb(1'b0, MODE_ADDR, 0); chk("mode reset", 0, rd);
		apb(1'b0, CMP_ADDR, 0); chk("cmp reset", 0, rd);
		apb(1'b0, 32'hffff_f8c0, 0); chk("unmapped err", 1, 32'(er));
		chk("unmapped data", 0, rd);
		v = $urandom_range(0, 127);
		apb(1'b1, MODE_ADDR, 32'(v)); apb(1'b0, MODE_ADDR, 0); chk("mode rw", 32'(v), rd);
		v = $urandom_range(0, 255);
		apb(1'b1, CMP_ADDR, 32'(v)); apb(1'b0, CMP_ADDR, 0); chk("cmp rw", 32'(v), rd);
		// low byte lane off: the compare byte must not change
		pstrb <= 4'he;
		apb(1'b1, CMP_ADDR, 32'(8'(~v)));
		pstrb <= 4'hf;
		apb(1'b0, CMP_ADDR, 0);
		chk("cmp strobe", 32'(v), rd);
		for (int m = 0; m < 4; m++) begin
			n = (m == 3) ? 0 : $urandom_range(2, 40);
			apb(1'b1, CMP_ADDR, 32'(n));
			apb(1'b1, MODE_ADDR, md(1'b0, 1'b0, 2'(m)));
			apb(1'b1, MODE_ADDR, md(1'b1, 1'b0, 2'(m)));
			next_irq(c);
			next_irq(c);
			chk("interval", gap(m, n), 32'(c));
			next_irq(c);
			@(posedge mclk);
			chk("watch period", gap(m, n) << 1, 32'(period));
			chk("pulse width", 0, 32'(interval_irq));
			apb(1'b1, MODE_ADDR, md(1'b0, 1'b0, 2'(m)));
			repeat (3) @(posedge mclk);
			chk("stopped clock", 0, 32'(watch_count_clk));
		end
		apb(1'b1, CMP_ADDR, 3);
		// gate and select set while stopped
		apb(1'b1, MODE_ADDR, md(1'b0, 1'b1, 2'h0));
		apb(1'b1, MODE_ADDR, md(1'b1, 1'b1, 2'h0));
		c = rises;
		repeat (3) next_irq(n);
		chk("gated rises", 32'(c), 32'(rises));
		apb(1'b1, CMP_ADDR, 1);
		apb(1'b1, MODE_ADDR, md(1'b0, 1'b1, 2'h0));
		apb(1'b1, MODE_ADDR, md(1'b0, 1'b0, 2'h0));
		apb(1'b1, MODE_ADDR, md(1'b1, 1'b0, 2'h0));
		n = 0;
		repeat (300) begin
			@(posedge mclk);
			if (interval_irq === 1'b1)
				n++;
		end
		chk("single pulse", 1, 32'(n));
		apb(1'b1, MODE_ADDR, 0);
		apb(1'b0, STAT_ADDR, 0); chk("status set", 1, rd);
		chk("irq masked", 0, 32'(irq));
		apb(1'b1, MASK_ADDR, 1); chk("irq on", 1, 32'(irq));
		apb(1'b1, STAT_ADDR, 1); chk("irq cleared", 0, 32'(irq));
		apb(1'b0, STAT_ADDR, 0); chk("status clear", 0, rd);
		// reset while stopped, with non-zero registers
		apb(1'b1, MODE_ADDR, md(1'b0, 1'b1, 2'h2));
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		apb(1'b0, MODE_ADDR, 0);
		chk("mode re-reset", 0, rd);
		apb(1'b0, CMP_ADDR, 0);
		chk("cmp re-reset", 0, rd);
		apb(1'b0, MASK_ADDR, 0);
		chk("mask re-reset", 0, rd);
		complete_run();
	end
endmodule

// File: hdl/itw_pkg.sv
/*
 * constants, field layout and carrier types of the interval timer
 * assumes a 32-bit apb register bus and a single main clock
 */
package itw_pkg;

	// ==========================================================
	// register map
	localparam logic [31:0] MODE_ADDR = 32'hffff_f8b0;
	localparam logic [31:0] CMP_ADDR  = 32'hffff_f8b4;
	localparam logic [31:0] STAT_ADDR = 32'hffff_f8b8;
	localparam logic [31:0] MASK_ADDR = 32'hffff_f8bc;

	// ==========================================================
	// reset values and counter constants
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET  = 8'h00;
	localparam logic [7:0] CNT_START  = 8'h01;
	localparam logic [7:0] CMP_ONCE   = 8'h01;
	localparam logic [7:0] CNT_WRAP   = 8'h00;
	localparam logic [2:0] PRE_ZERO   = 3'h0;
	localparam logic [2:0] PRE_ONE    = 3'h1;
	localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

	// ==========================================================
	// interrupt status and mask layout
	localparam int unsigned EVT_W     = 1;
	localparam int unsigned EVT_MATCH = 0;

	// ==========================================================
	// clock select encodings
	typedef enum logic [1:0] {
		SEL_DIV1 = 2'h0,
		SEL_DIV2 = 2'h1,
		SEL_DIV4 = 2'h2,
		SEL_DIV8 = 2'h3
	} itw_sel_t;

	// mode register layout, msb first
	typedef struct packed {
		logic       interval_run;
		logic       watch_clock_gate_off;
		logic [3:0] rsv;
		itw_sel_t   clock_select;
	} itw_mode_t;

endpackage

// File: hdl/itw_timer.sv
/*
 * interval timer with watch clock output, apb register slave and interrupt
 * assumes apb master on mclk, synchronous active low reset, one clock domain
 */
`timescale 1ns/1ps

module itw_timer
	import itw_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             interval_irq,
	output logic             watch_count_clk,
	output logic             irq
);

	// ==========================================================
	// state
	itw_mode_t         mode;
	logic [7:0]        cmp_val;
	logic [EVT_W-1:0]  stat;
	logic [EVT_W-1:0]  mask;
	logic [2:0]        pre;
	logic [7:0]        cnt;
	logic              fired_once;
	logic              toggle;
	logic              tick;
	logic              match;
	logic              next_toggle;
	logic              hit;
	logic              wr_acc;
	logic              wr_byte;
	logic [31:0]       next_rdata;

	function automatic logic is_mapped(input logic [31:0] a);
		is_mapped = (a == MODE_ADDR) || (a == CMP_ADDR) ||
			(a == STAT_ADDR) || (a == MASK_ADDR);
	endfunction

	function automatic logic sel_tick(input itw_sel_t s, input logic [2:0] p);
		case (s)
			SEL_DIV1: sel_tick = 1'b1;
			SEL_DIV2: sel_tick = p[0];
			SEL_DIV4: sel_tick = &p[1:0];
			SEL_DIV8: sel_tick = &p;
			default:  sel_tick = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// apb slave: zero wait states, read data caught in setup phase
	assign hit     = is_mapped(paddr);
	assign pready  = penable;
	assign pslverr = psel && penable && !hit;
	assign wr_acc  = psel && penable && pwrite && hit;
	assign wr_byte = wr_acc && pstrb[0];

	always_comb begin
		next_rdata = RD_ZERO;
		case (paddr)
			MODE_ADDR: next_rdata[7:0] = mode;
			CMP_ADDR:  next_rdata[7:0] = cmp_val;
			STAT_ADDR: next_rdata[EVT_W-1:0] = stat;
			MASK_ADDR: next_rdata[EVT_W-1:0] = mask;
			default:   next_rdata = RD_ZERO;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prdata <= RD_ZERO;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	// ==========================================================
	// software registers
	// reset to 00H
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mode <= MODE_RESET;
		end else if (wr_byte && paddr == MODE_ADDR) begin
			mode <= pwdata[7:0];
		end
	end

	// compare is taken whole; a new value applies at the next match check
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cmp_val <= CMP_RESET;
		end else if (wr_byte && paddr == CMP_ADDR) begin
			cmp_val <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mask <= '0;
		end else if (wr_byte && paddr == MASK_ADDR) begin
			mask <= pwdata[EVT_W-1:0];
		end
	end

	// sticky status: interval_irq in the clearing cycle still sets the bit
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			stat <= '0;
		end else begin
			if (wr_byte && paddr == STAT_ADDR) begin
				stat <= stat & ~pwdata[EVT_W-1:0];
			end
			if (interval_irq) begin
				stat[EVT_MATCH] <= 1'b1;
			end
		end
	end

	assign irq = |(stat & mask);

	// ==========================================================
	// prescaler and selector
	// free divider while running
	always_ff @(posedge mclk) begin
		if (!rstn || !mode.interval_run) begin
			pre <= PRE_ZERO;
		end else begin
			pre <= pre + PRE_ONE;
		end
	end

	assign tick = mode.interval_run && sel_tick(mode.clock_select, pre);

	// ==========================================================
	// 8-bit counter
	// compare 00H matches after wrap
	assign match = tick && (cnt == cmp_val);

	always_ff @(posedge mclk) begin
		if (!rstn || !mode.interval_run) begin
			cnt <= CNT_START;
		end else if (match) begin
			cnt <= CNT_START;
		end else if (tick) begin
			cnt <= cnt + CNT_START;
		end
	end

	// remembers the first match since start
	always_ff @(posedge mclk) begin
		if (!rstn || !mode.interval_run) begin
			fired_once <= 1'b0;
		end else if (match) begin
			fired_once <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			interval_irq <= 1'b0;
		end else begin
			interval_irq <= match && !(cmp_val == CMP_ONCE && fired_once);
		end
	end

	// ==========================================================
	// watch clock output
	// halving stage
	assign next_toggle = mode.interval_run && (toggle ^ match);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			toggle <= 1'b0;
		end else begin
			toggle <= next_toggle;
		end
	end

	// gate, kept in a flop so the output has no glitches
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			watch_count_clk <= 1'b0;
		end else begin
			watch_count_clk <= next_toggle && !mode.watch_clock_gate_off;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_match_now;
		match && mode.interval_run;
	endsequence

	sequence s_reload;
		##1 cnt == CNT_START;
	endsequence

	a_stop_holds_start: assert property (!mode.interval_run |=> cnt == CNT_START)
		else $error("counter not held at start while stopped");

	a_match_reloads: assert property (s_match_now |-> s_reload)
		else $error("counter not reloaded after match");

	a_wrap_is_256: assert property (
		tick && cmp_val == CNT_WRAP && cnt != CNT_WRAP |=> cnt == 8'($past(cnt) + CNT_START))
		else $error("compare zero reloaded before full count");

	a_div8_spacing: assert property (
		tick && mode.clock_select == SEL_DIV8 |=> (!tick) [*7])
		else $error("divide by eight tick spacing wrong");

	a_div4_spacing: assert property (
		tick && mode.clock_select == SEL_DIV4 |=> (!tick) [*3])
		else $error("divide by four tick spacing wrong");

	a_irq_follows: assert property (
		match && !fired_once |=> interval_irq && $past(cnt) == $past(cmp_val))
		else $error("request missing after first match");

	a_single_shot: assert property (
		match && fired_once && cmp_val == CMP_ONCE |=> !interval_irq)
		else $error("compare one repeated its request");

	a_gate_blocks: assert property (mode.watch_clock_gate_off |=> !watch_count_clk)
		else $error("watch clock passed while gated off");

	a_watch_toggle: assert property (
		match && !mode.watch_clock_gate_off ##1 !mode.watch_clock_gate_off
		|-> watch_count_clk != $past(watch_count_clk))
		else $error("watch clock did not toggle on match");

	a_irq_pulse: assert property (interval_irq |=> !interval_irq)
		else $error("request stretched without a match");

	a_reset_zero: assert property (
		$rose(rstn) |-> mode == MODE_RESET && cmp_val == CMP_RESET)
		else $error("registers not zero after reset");

	a_byte_write: assert property (
		wr_byte && paddr == CMP_ADDR |=> cmp_val == $past(pwdata[7:0]))
		else $error("compare byte write lost");

endmodule
